// *** core/sdram_cfg_consts.svh ***
// constants for the sdram timing and block size configuration
`ifndef SDRAM_CFG_CONSTS_SVH
`define SDRAM_CFG_CONSTS_SVH

// timing word field positions (little-endian bit numbers of the 32-bit word)
`define TRC_LSB        24
`define CL3_BIT        28
`define TRAS_LSB       20
`define TRP_BIT        12
`define TRCD_BIT       8

// power-up values: slowest settings
`define TRC_RESET      3'h3
`define TRAS_RESET     2'h3
`define TRP_RESET      1'h1
`define TRCD_RESET     1'h1
`define CL3_RESET      1'h1
`define TIMING_RESET   32'h1330_1100

// block register layouts
`define SIZE_LSB       0
`define ENABLE_BIT     7
`define SIZE_RESET     8'h00
`define BASE_RESET     8'h00

// clock offsets of the timing codes
`define TRAS_BASE_CLKS 4'h4
`define TRP_BASE_CLKS  4'h2
`define TRCD_BASE_CLKS 4'h2
`define TRC_WRAP_CLKS  4'h8
`define TRC_MAX_CLKS   4'hB

// read data latency in clocks
`define CL_SHORT       2
`define CL_LONG        3

`endif

// *** core/sdram_cfg_pkg.sv ***
// types shared by the sdram timing and size configuration block
package sdram_cfg_pkg;

	// decoded minimum timings, in bus clocks
	typedef struct packed {
		logic [3:0] act_clks;
		logic [3:0] pre_clks;
		logic [3:0] rcd_clks;
		logic [3:0] rc_clks;
		logic       cas_latency_three;
	} timing_t;

	// processor-side access request
	typedef struct packed {
		logic [31:0] addr;
		logic        read_cmd;
	} mem_req_t;

	// translated sdram address
	typedef struct packed {
		logic [12:0] row;
		logic [1:0]  bank;
		logic [9:0]  col;
	} sdram_addr_t;

endpackage

// *** core/sdram_timing_size_config.sv ***
// timing attributes, per-block size/base/enable, decode and translation
// Notes on behaviour
// - one shared 32-bit timing word
// - per-block 8-bit size/enable and base registers
// - timing resets to slowest supported settings
// - every block size clears at reset
// - size drives hit decode and row/column mapping
// - non-zero size blocks join enabled scrubbing
// - two-bit active code: 4 to 7 clocks
// - precharge bit: 2 or 3 clocks
// - activate-to-access bit: 2 or 3 clocks
// - row-cycle code wraps 6,7,8..11 clocks
`timescale 1ns/10ps
`include "sdram_cfg_consts.svh"

module sdram_timing_size_config #(
	parameter int NUM_BLOCKS = 8
) (
	// clock and reset
	input  wire logic                              clock,
	input  wire logic                              rst_b,
	// timing word write and readback
	input  wire logic                              timing_wr,
	input  wire logic [31:0]                       timing_wdata,
	output logic [31:0]                            timing_word,
	output sdram_cfg_pkg::timing_t                 timing,
	// block register writes
	input  wire logic                              blk_size_wr,
	input  wire logic                              blk_base_wr,
	input  wire logic [2:0]                        blk_index,
	input  wire logic [7:0]                        blk_wdata,
	output logic [NUM_BLOCKS-1:0][7:0]             blk_size_en,
	output logic [NUM_BLOCKS-1:0][7:0]             blk_base,
	// processor access and decode result
	input  wire sdram_cfg_pkg::mem_req_t           req,
	output logic [NUM_BLOCKS-1:0]                  blk_hit,
	output sdram_cfg_pkg::sdram_addr_t             xlate,
	output logic                                   read_data_strobe,
	// scrubbing
	input  wire logic                              scrub_enable,
	output logic [NUM_BLOCKS-1:0]                  scrub_member
);
	import sdram_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// block index port is three bits, so no more than eight blocks
	if (NUM_BLOCKS < 1 || NUM_BLOCKS > 8) begin : g_bad_blocks
		$error("NUM_BLOCKS must lie between 1 and 8");
	end

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [31:0]                  timing_word;  // shared timing word
		timing_t                      timing;       // decoded clocks
		logic [NUM_BLOCKS-1:0][7:0]   size_en;      // enable and size code
		logic [NUM_BLOCKS-1:0][7:0]   base;         // base address bits 31:24
		logic [NUM_BLOCKS-1:0]        hit;          // decode result
		sdram_addr_t                  xlate;        // translated address
		logic [1:0]                   rd_pipe;      // read command delay line
		logic                         rd_strobe;    // read data valid
		logic [NUM_BLOCKS-1:0]        scrub;        // scrub participation
	} state_t;

	state_t state_q;
	state_t state_d;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// log2 of block size in bytes for each size code; zero means absent
	function automatic logic [4:0] size_log2(input logic [3:0] code);
		case (code)
			4'h1:                 size_log2 = 5'h19;
			4'h2, 4'h3:           size_log2 = 5'h1A;
			4'h4, 4'h5, 4'h6:     size_log2 = 5'h1B;
			4'h7, 4'h8:           size_log2 = 5'h1C;
			4'h9:                 size_log2 = 5'h1D;
			default:              size_log2 = 5'h00;
		endcase
	endfunction

	// column bits from the device width implied by the size code
	function automatic logic [3:0] col_bits(input logic [3:0] code);
		case (code)
			4'h1, 4'h3, 4'h6:     col_bits = 4'h8;  // x16 parts
			4'h2, 4'h5, 4'h8:     col_bits = 4'h9;  // x8 parts
			default:              col_bits = 4'hA;  // x4 parts
		endcase
	endfunction

	// decode the timing word into clock counts
	function automatic timing_t decode_timing(input logic [31:0] w);
		timing_t     t;
		logic [2:0]  rc;
		rc = w[`TRC_LSB +: 3];
		t.act_clks = `TRAS_BASE_CLKS + {2'h0, w[`TRAS_LSB +: 2]};
		t.pre_clks = `TRP_BASE_CLKS + {3'h0, w[`TRP_BIT]};
		t.rcd_clks = `TRCD_BASE_CLKS + {3'h0, w[`TRCD_BIT]};
		// codes 6 and 7 stand for themselves, 0..3 wrap to 8..11
		if (rc >= 3'h6) begin
			t.rc_clks = {1'b0, rc};
		end else if (rc <= 3'h3) begin
			t.rc_clks = `TRC_WRAP_CLKS + {1'b0, rc};
		end else begin
			// illegal codes fall back to the longest row cycle
			t.rc_clks = `TRC_MAX_CLKS;
		end
		t.cas_latency_three = w[`CL3_BIT];
		decode_timing = t;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [4:0]  lg;
		logic [7:0]  mask;
		logic [3:0]  cb;
		logic [31:0] sh;
		logic        found;
		lg = 5'h00;
		mask = 8'h00;
		cb = 4'h0;
		sh = 32'h0000_0000;
		found = 1'b0;
		state_d = state_q;

		// shared timing word, one register for all blocks
		if (timing_wr) begin
			state_d.timing_word = timing_wdata;
		end
		state_d.timing = decode_timing(state_d.timing_word);

		// per-block registers; an index past the last block is ignored
		if (32'(blk_index) < NUM_BLOCKS) begin
			if (blk_size_wr) begin
				state_d.size_en[blk_index] = blk_wdata;
			end
			if (blk_base_wr) begin
				state_d.base[blk_index] = blk_wdata;
			end
		end

		// address decode and translation from the programmed sizes
		state_d.xlate = '0;
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			lg = size_log2(state_q.size_en[i][`SIZE_LSB +: 4]);
			// mask out base bits that fall inside the block
			mask = (lg == 5'h00) ? 8'h00 : 8'(8'hFF << (lg - 5'h18));
			state_d.hit[i] = state_q.size_en[i][`ENABLE_BIT] && (lg != 5'h00)
				&& ((req.addr[31:24] & mask) == (state_q.base[i] & mask));
			// first hitting block wins; overlap is a software fault
			if (state_d.hit[i] && !found) begin
				found = 1'b1;
				cb = col_bits(state_q.size_en[i][`SIZE_LSB +: 4]);
				sh = req.addr >> 3;  // eight bytes per location
				state_d.xlate.col = 10'(sh & ((32'h1 << cb) - 32'h1));
				sh = sh >> cb;
				state_d.xlate.bank = sh[1:0];
				state_d.xlate.row = 13'(sh >> 2);
			end
			// only blocks with a non-zero size are scrubbed
			state_d.scrub[i] = scrub_enable && (state_q.size_en[i][`SIZE_LSB +: 4] != 4'h0);
		end

		// read data timing from the latency choice
		state_d.rd_pipe = {state_q.rd_pipe[0], req.read_cmd};
		state_d.rd_strobe = state_q.timing.cas_latency_three ? state_q.rd_pipe[1] : state_q.rd_pipe[0];
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	// slowest timings at reset so sdram works before real timings are known
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= '0;
			state_q.timing_word <= `TIMING_RESET;
			state_q.timing.act_clks <= `TRAS_BASE_CLKS + {2'h0, `TRAS_RESET};
			state_q.timing.pre_clks <= `TRP_BASE_CLKS + {3'h0, `TRP_RESET};
			state_q.timing.rcd_clks <= `TRCD_BASE_CLKS + {3'h0, `TRCD_RESET};
			state_q.timing.rc_clks <= `TRC_WRAP_CLKS + {1'b0, `TRC_RESET};
			state_q.timing.cas_latency_three <= `CL3_RESET;
			state_q.size_en <= {NUM_BLOCKS{`SIZE_RESET}};
			state_q.base <= {NUM_BLOCKS{`BASE_RESET}};
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, straight from the state flops

	assign timing_word      = state_q.timing_word;
	assign timing           = state_q.timing;
	assign blk_size_en      = state_q.size_en;
	assign blk_base         = state_q.base;
	assign blk_hit          = state_q.hit;
	assign xlate            = state_q.xlate;
	assign read_data_strobe = state_q.rd_strobe;
	assign scrub_member     = state_q.scrub;

endmodule

// *** verif/sdram_cfg_props.sv ***
// assertions on the timing and block configuration ports
`timescale 1ns/10ps
module sdram_cfg_props import sdram_cfg_pkg::*; #(
	parameter int NUM_BLOCKS = 8
) (
	// clock and reset
	input logic                        clock,
	input logic                        rst_b,
	// timing word
	input logic                        timing_wr,
	input logic [31:0]                 timing_wdata,
	input logic [31:0]                 timing_word,
	input timing_t                     timing,
	// block registers
	input logic                        blk_size_wr,
	input logic [2:0]                  blk_index,
	input logic [7:0]                  blk_wdata,
	input logic [NUM_BLOCKS-1:0][7:0]  blk_size_en,
	// decode, read timing and scrubbing
	input mem_req_t                    req,
	input logic [NUM_BLOCKS-1:0]       blk_hit,
	input logic                        read_data_strobe,
	input logic                        scrub_enable,
	input logic [NUM_BLOCKS-1:0]       scrub_member
);
	logic [NUM_BLOCKS-1:0] scr_x, hit_ok; // expected scrub set, blocks allowed to hit
	// a zero size code counts as an absent block
	always_comb begin
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			scr_x[i] = scrub_enable && blk_size_en[i][3:0] != 4'h0;
			hit_ok[i] = blk_size_en[i][7] && blk_size_en[i][3:0] != 4'h0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_act_decode: assert property (timing.act_clks == 4'h4 + timing_word[21:20])
		else $error("active clocks wrong");
	a_pre_decode: assert property (timing.pre_clks == 4'h2 + timing_word[12])
		else $error("precharge clocks wrong");
	a_rcd_decode: assert property (timing.rcd_clks == 4'h2 + timing_word[8])
		else $error("activate delay wrong");
	a_rc_decode: assert property (timing.rc_clks == (
		timing_word[26:25] == 2'h3 ? {1'b0, timing_word[26:24]} :
		timing_word[26] ? 4'hB : 4'h8 + timing_word[25:24])) else $error("row cycle wrong");
	a_timing_write: assert property (timing_wr |=> timing_word == $past(timing_wdata))
		else $error("timing word not written");
	a_size_write: assert property (blk_size_wr && blk_index == 3'h0 |=> blk_size_en[0] == $past(blk_wdata))
		else $error("size register not written");
	a_hit_enabled: assert property ((blk_hit & ~$past(hit_ok)) == '0)
		else $error("hit on absent block");
	a_scrub_set: assert property (scrub_member == $past(scr_x))
		else $error("scrub membership wrong");
	// latency choice is the one held at the edge that launches the strobe, registered one edge earlier
	a_read_latency: assert property (read_data_strobe == (
		$past(req.read_cmd, 2) && !$past(timing.cas_latency_three) ||
		$past(req.read_cmd, 3) && $past(timing.cas_latency_three))) else $error("read strobe mistimed");
	c_read: cover property (read_data_strobe);
	c_hit: cover property (|blk_hit);
	c_scrub: cover property (|scrub_member);
endmodule

// *** verif/sdram_blk_model.sv ***
// memory blocks on the far side: count read beats the controller schedules
`timescale 1ns/10ps
module sdram_blk_model (
	input logic clock, rst_b, read_data_strobe,
	output logic [7:0] n_beats_q
);
	// one beat per strobe; a missing or doubled strobe shows in the count
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) n_beats_q <= 8'h00;
		else if (read_data_strobe) n_beats_q <= n_beats_q + 8'h01;
	end
endmodule

// *** verif/sdram_timing_size_config_tb.sv ***
// self-checking bench for the timing and block configuration
`timescale 1ns/10ps
module sdram_timing_size_config_tb;
	import sdram_cfg_pkg::*;
	localparam int NUM_BLOCKS = 4; // index 7 then lies out of range
	logic clock, rst_b, timing_wr, blk_size_wr, blk_base_wr, scrub_enable, read_data_strobe;
	logic [31:0] timing_wdata, timing_word, w;
	logic [2:0] blk_index;
	logic [7:0] blk_wdata, n_beats_q;
	logic [NUM_BLOCKS-1:0][7:0] blk_size_en, blk_base;
	logic [NUM_BLOCKS-1:0] blk_hit, scrub_member;
	timing_t timing;
	mem_req_t req;
	sdram_addr_t xlate;
	int n_errors, comparisons, cycles, k;
	sdram_timing_size_config #(.NUM_BLOCKS(NUM_BLOCKS)) DUT (.clock(clock), .rst_b(rst_b), .timing_wr(timing_wr),
		.timing_wdata(timing_wdata), .timing_word(timing_word), .timing(timing), .blk_size_wr(blk_size_wr),
		.blk_base_wr(blk_base_wr), .blk_index(blk_index), .blk_wdata(blk_wdata), .blk_size_en(blk_size_en),
		.blk_base(blk_base), .req(req), .blk_hit(blk_hit), .xlate(xlate), .read_data_strobe(read_data_strobe),
		.scrub_enable(scrub_enable), .scrub_member(scrub_member));
	sdram_blk_model mem (.clock(clock), .rst_b(rst_b), .read_data_strobe(read_data_strobe), .n_beats_q(n_beats_q));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task step();
		@(posedge clock);
		#1;
	endtask
	task wr_timing(input logic [31:0] d);
		timing_wr = 1'b1;
		timing_wdata = d;
		step();
		timing_wr = 1'b0;
		// one idle edge so a following write never re-raises the strobe at once
		step();
	endtask
	task wr_blk(input logic base, input logic [2:0] i, input logic [7:0] d);
		blk_base_wr = base;
		blk_size_wr = !base;
		blk_index = i;
		blk_wdata = d;
		step();
		blk_base_wr = 1'b0;
		blk_size_wr = 1'b0;
		// one idle edge between writes
		step();
	endtask
	// count edges from the taking edge to the strobe, then see it drop
	task rd(input int lat);
		req.read_cmd = 1'b1;
		step();
		req.read_cmd = 1'b0;
		k = 1;
		while (read_data_strobe !== 1'b1 && k < 8) begin
			step();
			k++;
		end
		check(k, lat);
		step();
		check(read_data_strobe, 1'b0);
	endtask
	function automatic logic [3:0] rc_of(input int c);
		return c == 6 ? 4'h6 : c == 7 ? 4'h7 : c > 3 ? 4'hB : 4'h8 + c[3:0];
	endfunction
	task stop_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{rst_b, timing_wr, blk_size_wr, blk_base_wr, scrub_enable} = '0;
		{timing_wdata, blk_index, blk_wdata, req} = '0;
		repeat (6) @(posedge clock);
		#1 rst_b = 1'b1;
		check(timing_word, 32'h1330_1100);
		check(timing, {4'h7, 4'h3, 4'h3, 4'hB, 1'b1});
		check(blk_size_en, 32'h0);
		rd(3);
		// every code of each timing field, latency two; no sdram reads meanwhile
		for (int i = 0; i < 8; i++) begin
			w = {5'h0, i[2:0], 2'h0, i[1:0], 7'h0, i[0], 3'h0, i[1], 8'h0};
			wr_timing(w);
			check(timing_word, w);
			check(timing, {4'h4 + i[1:0], 4'h2 + i[0], 4'h2 + i[1], rc_of(i), 1'b0});
		end
		rd(2);
		// a slow block needs latency three; all other codes zero
		wr_timing(32'h1000_0000);
		check(timing, {4'h4, 4'h2, 4'h2, 4'h8, 1'b1});
		rd(3);
		// scratch block 0: base on a 32MB multiple, 4Mx16 size, enable last
		wr_blk(1'b1, 3'h0, 8'h02);
		wr_blk(1'b0, 3'h0, 8'h01);
		// stand-in for the refresh interval before enabling
		repeat (4) step();
		wr_blk(1'b0, 3'h0, 8'h81);
		// block 1 sized only, base zero is a 64MB multiple
		wr_blk(1'b0, 3'h1, 8'h03);
		// index past the last block: nothing present there, write ignored
		wr_blk(1'b0, 3'h7, 8'h85);
		check(blk_size_en, 32'h0000_0381);
		check(blk_base, 32'h0000_0002);
		// 32MB x16 block: col 8 bits, bank 2 bits, row the rest of addr>>3
		req.addr = 32'h0212_3458;
		step();
		check(blk_hit, 4'h1);
		check(xlate, 32'h0109_188B);
		req.addr = 32'h0400_0000;
		step();
		check(blk_hit, 4'h0);
		check(xlate, 32'h0);
		// block 1 matches this address but is not enabled
		req.addr = 32'h0000_0000;
		step();
		check(blk_hit, 4'h0);
		scrub_enable = 1'b1;
		step();
		check(scrub_member, 4'h3);
		// failed scratch test: block 0 disabled and sized to zero
		wr_blk(1'b0, 3'h0, 8'h00);
		check(scrub_member, 4'h2);
		scrub_enable = 1'b0;
		step();
		check(scrub_member, 4'h0);
		check(n_beats_q, 8'h03);
		// second reset in mid-run brings back power-up values
		rst_b = 1'b0;
		step();
		check(timing_word, 32'h1330_1100);
		check(blk_size_en, 32'h0);
		rst_b = 1'b1;
		rd(3);
		stop_test();
	end
endmodule
bind sdram_timing_size_config sdram_cfg_props #(.NUM_BLOCKS(NUM_BLOCKS)) props (
	.clock(clock),
	.rst_b(rst_b),
	.timing_wr(timing_wr),
	.timing_wdata(timing_wdata),
	.timing_word(timing_word),
	.timing(timing),
	.blk_size_wr(blk_size_wr),
	.blk_index(blk_index),
	.blk_wdata(blk_wdata),
	.blk_size_en(blk_size_en),
	.req(req),
	.blk_hit(blk_hit),
	.read_data_strobe(read_data_strobe),
	.scrub_enable(scrub_enable),
	.scrub_member(scrub_member)
);
